// ---- rtl/clock_controller.sv ----
// Contract
// - Three root sources: ring, reference, external.
// - Reset runs everything but power manager clock from ring oscillator.
// - Ring clock selectable, always feeds watchdog.
// - Software can switch ring oscillator off.
// - Reference selectable; clocks power manager logic.
// - External input selectable; supplier keeps it at most 20MHz.
// - PLL 1-50MHz in, output config held here.
// - PLL enable and bypass independent of config.
// - System mux picks PLL or free-running clock.
// - Free-running clock stays on when others gated.
// - Auxiliary and AHB clocks have 3-bit dividers.
// - Auxiliary clock stops in deep sleep.
// - AHB clock divided and software gateable.
// - Peripheral clock derives from AHB clock.
// - Peripheral clock has divider and gate.
`timescale 1ns/10ps
`default_nettype none

module clock_controller
   import clk_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // APB slave
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [ADDR_W-1:0]    paddr,
   input  wire logic [31:0]          pwdata,
   output logic [31:0]               prdata,
   output logic                      pready,
   output logic                      pslverr,
   // Root clock sources, sampled levels
   input  wire logic                 ring_osc_clock,
   input  wire logic                 reference_clock,
   input  wire logic                 external_input_clock,
   // PLL analog macro
   input  wire logic                 pll_output_clock,
   input  wire logic                 pll_lock,
   output logic                      pll_enable,
   output logic                      pll_bypass,
   output logic [PLL_CFG_W-1:0]      pll_config,
   // Oscillator control and core state
   output logic                      ring_osc_enable,
   input  wire logic                 deep_sleep,
   // Clock tree outputs
   output logic                      free_running_clock,
   output logic                      windowed_watchdog_clock,
   output logic                      power_manager_logic_clock,
   output logic                      system_clock,
   output logic                      aux_clock,
   output logic                      ahb_clock,
   output logic                      periph_clock
);

   // ------------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------------
   logic [SEL_W-1:0]     fr_sel_q;
   logic                 sys_pll_q;
   logic                 ring_off_q;
   logic                 pll_en_q;
   logic                 pll_byp_q;
   logic [PLL_CFG_W-1:0] pll_cfg_q;
   logic [DIV_W-1:0]     div_a_q;
   logic [DIV_W-1:0]     div_h_q;
   logic [DIV_W-1:0]     div_p_q;
   logic                 stop_h_q;
   logic                 stop_p_q;
   logic                 pready_q;
   logic                 pslverr_q;
   logic [31:0]          prdata_q;
   logic                 wdt_q;
   logic                 pm_q;

   // ------------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------------
   // One wait state: pready rises in the second access cycle, which keeps
   // prdata and pslverr straight from flip-flops.
   wire logic            access   = psel & penable;
   wire logic            wr_take  = access & pready_q & pwrite;
   wire logic            hit_src  = (paddr == ADDR_SRC);
   wire logic            hit_pll  = (paddr == ADDR_PLL);
   wire logic            hit_div  = (paddr == ADDR_DIV);
   wire logic            hit_gate = (paddr == ADDR_GATE);
   wire logic            hit_stat = (paddr == ADDR_STAT);
   wire logic            hit_any  = hit_src | hit_pll | hit_div | hit_gate | hit_stat;
   wire logic            hit_rw   = hit_src | hit_pll | hit_div | hit_gate;
   // Status is read-only; a write to it is answered with an error.
   wire logic            bad      = !hit_any | (pwrite & hit_stat);

   // ------------------------------------------------------------------
   // Clock tree wiring
   // ------------------------------------------------------------------
   wire logic [2:0]       roots;
   wire logic [SEL_W-1:0] fr_eff;
   wire logic             fr_clk;
   wire logic [SEL_W-1:0] fr_active;
   wire logic             fr_busy;
   wire logic             pll_path;
   wire logic [1:0]       sys_in;
   wire logic             sys_clk;
   wire logic             sys_active;
   wire logic             sys_busy;
   wire logic             h_clk;
   wire logic             a_clk;
   wire logic             p_clk;

   assign roots = {external_input_clock, reference_clock, ring_osc_clock};

   // external and reference selectable
   // The spare code falls back to the ring oscillator rather than a dead input.
   assign fr_eff = (fr_sel_q == SRC_EXT || fr_sel_q == SRC_REF) ? fr_sel_q : SRC_RING;

   // bypass passes the free-running clock
   // Bypass wins over enable; a disabled PLL feeds a constant low into the mux.
   assign pll_path = pll_byp_q ? fr_clk : (pll_en_q & pll_output_clock);

   // system mux from PLL or free-running
   assign sys_in  = {pll_path, fr_clk};

   // ------------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------------
   wire logic [31:0] src_word  = (32'(fr_sel_q) << FR_SEL_LSB) | (32'(sys_pll_q) << SYS_SEL_BIT)
                               | (32'(ring_off_q) << RING_OFF_BIT);
   wire logic [31:0] pll_word  = (32'(pll_en_q) << PLL_EN_BIT) | (32'(pll_byp_q) << PLL_BYP_BIT)
                               | (32'(pll_cfg_q) << PLL_CFG_LSB);
   wire logic [31:0] div_word  = (32'(div_a_q) << DIV_A_LSB) | (32'(div_h_q) << DIV_H_LSB)
                               | (32'(div_p_q) << DIV_P_LSB);
   wire logic [31:0] gate_word = (32'(stop_h_q) << GATE_H_BIT) | (32'(stop_p_q) << GATE_P_BIT);
   wire logic [31:0] stat_word = (32'(fr_active) << STAT_FR_LSB) | (32'(sys_active) << STAT_SYS_BIT)
                               | (32'(fr_busy) << STAT_FRB_BIT) | (32'(sys_busy) << STAT_SYSB_BIT)
                               | (32'(pll_lock) << STAT_LOCK_BIT);
   wire logic [31:0] rd_word   = hit_src ? src_word : hit_pll ? pll_word : hit_div ? div_word
                               : hit_gate ? gate_word : hit_stat ? stat_word : ZERO_WORD;

   // ------------------------------------------------------------------
   // APB handshake
   // ------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= ZERO_WORD;
      end
      else
      begin
         pready_q  <= access & !pready_q;
         pslverr_q <= access & !pready_q & bad;
         prdata_q  <= (access & !pready_q & !pwrite) ? rd_word : ZERO_WORD;
      end
   end

   // ------------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------------
   // reset defaults
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fr_sel_q   <= SRC_RING;
         sys_pll_q  <= 1'b0;
         ring_off_q <= 1'b0;
         pll_en_q   <= 1'b0;
         pll_byp_q  <= 1'b0;
         pll_cfg_q  <= PLL_CFG_RST;
         div_a_q    <= DIV_BY_ONE;
         div_h_q    <= DIV_BY_ONE;
         div_p_q    <= DIV_BY_ONE;
         stop_h_q   <= 1'b0;
         stop_p_q   <= 1'b0;
      end
      else if (wr_take & hit_rw)
      begin
         if (hit_src)
         begin
            fr_sel_q   <= pwdata[FR_SEL_LSB +: SEL_W];
            sys_pll_q  <= pwdata[SYS_SEL_BIT];
            ring_off_q <= pwdata[RING_OFF_BIT];
         end
         if (hit_pll)
         begin
            pll_en_q  <= pwdata[PLL_EN_BIT];
            pll_byp_q <= pwdata[PLL_BYP_BIT];
            pll_cfg_q <= pwdata[PLL_CFG_LSB +: PLL_CFG_W];
         end
         if (hit_div)
         begin
            div_a_q <= pwdata[DIV_A_LSB +: DIV_W];
            div_h_q <= pwdata[DIV_H_LSB +: DIV_W];
            div_p_q <= pwdata[DIV_P_LSB +: DIV_W];
         end
         if (hit_gate)
         begin
            stop_h_q <= pwdata[GATE_H_BIT];
            stop_p_q <= pwdata[GATE_P_BIT];
         end
      end
   end

   // ------------------------------------------------------------------
   // Dedicated low-power clocks
   // ------------------------------------------------------------------
   // These never pass through a gate, so the watchdog and power manager keep
   // running when software stops the rest of the tree.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wdt_q <= 1'b0;
         pm_q  <= 1'b0;
      end
      else
      begin
         wdt_q <= ring_osc_clock;
         pm_q  <= reference_clock;
      end
   end

   // ------------------------------------------------------------------
   // Switches and dividers
   // ------------------------------------------------------------------
   // glitch-free source switch
   clk_switch #(.N(3)) u_fr_switch (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_in  (roots),
      .sel     (fr_eff),
      .clk_out (fr_clk),
      .active  (fr_active),
      .busy    (fr_busy)
   );

   clk_switch #(.N(2)) u_sys_switch (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_in  (sys_in),
      .sel     (sys_pll_q),
      .clk_out (sys_clk),
      .active  (sys_active),
      .busy    (sys_busy)
   );

   clk_div_gate u_hclk (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_in  (sys_clk),
      .div     (div_h_q),
      .run     (!stop_h_q),
      .clk_out (h_clk)
   );

   // auxiliary gate closes in deep sleep
   clk_div_gate u_aclk (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_in  (sys_clk),
      .div     (div_a_q),
      .run     (!deep_sleep),
      .clk_out (a_clk)
   );

   clk_div_gate u_pclk (
      .pclk    (pclk),
      .presetn (presetn),
      .clk_in  (h_clk),
      .div     (div_p_q),
      .run     (!stop_p_q),
      .clk_out (p_clk)
   );

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // free-running clock left ungated
   assign free_running_clock        = fr_clk;
   assign windowed_watchdog_clock   = wdt_q;
   assign power_manager_logic_clock = pm_q;
   assign system_clock              = sys_clk;
   assign aux_clock                 = a_clk;
   assign ahb_clock                 = h_clk;
   assign periph_clock              = p_clk;
   assign ring_osc_enable           = !ring_off_q;
   assign pll_enable                = pll_en_q;
   assign pll_bypass                = pll_byp_q;
   assign pll_config                = pll_cfg_q;
   assign prdata                    = prdata_q;
   assign pready                    = pready_q;
   assign pslverr                   = pslverr_q;

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_apb_one_wait: assert property ((access && !pready_q) |=> pready_q ##1 !pready_q)
      else $error("pready not a single pulse after one wait state");
   a_src_write: assert property ((wr_take && hit_src) |=> fr_sel_q == $past(pwdata[FR_SEL_LSB +: SEL_W]))
      else $error("source select did not take the written value");
   a_ring_enable: assert property ((wr_take && hit_src) |=> ring_osc_enable == !$past(pwdata[RING_OFF_BIT]))
      else $error("ring oscillator enable does not track its control");
   a_pll_disabled: assert property ((!pll_en_q && !pll_byp_q) |-> !pll_path)
      else $error("disabled PLL still drives the system mux");
   a_aclk_sleep: assert property ((deep_sleep && !aux_clock) |=> !aux_clock)
      else $error("auxiliary clock rose in deep sleep");
   a_wdt_ring: assert property ($rose(ring_osc_clock) |=> windowed_watchdog_clock)
      else $error("watchdog clock does not follow the ring oscillator");
   a_pm_ref: assert property ($fell(reference_clock) |=> !power_manager_logic_clock)
      else $error("power manager clock does not follow the reference");
   a_slverr_map: assert property ((access && !pready_q && !hit_any) |=> pslverr)
      else $error("unmapped access not flagged");

endmodule : clock_controller

`default_nettype wire

// ---- rtl/clk_ctrl_pkg.sv ----
package clk_ctrl_pkg;

   // ------------------------------------------------------------------
   // Register map, byte addresses on the APB bus
   // ------------------------------------------------------------------
   localparam int          ADDR_W        = 12;
   localparam logic [11:0] ADDR_SRC      = 12'h000;
   localparam logic [11:0] ADDR_PLL      = 12'h004;
   localparam logic [11:0] ADDR_DIV      = 12'h008;
   localparam logic [11:0] ADDR_GATE     = 12'h00c;
   localparam logic [11:0] ADDR_STAT     = 12'h010;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int          FR_SEL_LSB    = 0;
   localparam int          SEL_W         = 2;
   localparam int          SYS_SEL_BIT   = 4;
   localparam int          RING_OFF_BIT  = 8;
   localparam int          PLL_EN_BIT    = 0;
   localparam int          PLL_BYP_BIT   = 1;
   localparam int          PLL_CFG_LSB   = 8;
   localparam int          PLL_CFG_W     = 16;
   localparam int          DIV_W         = 3;
   localparam int          DIV_A_LSB     = 0;
   localparam int          DIV_H_LSB     = 4;
   localparam int          DIV_P_LSB     = 8;
   localparam int          GATE_H_BIT    = 0;
   localparam int          GATE_P_BIT    = 1;
   localparam int          STAT_FR_LSB   = 0;
   localparam int          STAT_SYS_BIT  = 4;
   localparam int          STAT_FRB_BIT  = 8;
   localparam int          STAT_SYSB_BIT = 9;
   localparam int          STAT_LOCK_BIT = 12;

   // ------------------------------------------------------------------
   // Reset values and encodings
   // ------------------------------------------------------------------
   localparam logic [1:0]  SRC_RING      = 2'h0;
   localparam logic [1:0]  SRC_REF       = 2'h1;
   localparam logic [1:0]  SRC_EXT       = 2'h2;
   localparam logic [1:0]  SYS_FROM_FR   = 2'h0;
   localparam logic [1:0]  SYS_FROM_PLL  = 2'h1;
   localparam logic [DIV_W-1:0] DIV_BY_ONE = 3'h0;
   localparam logic [PLL_CFG_W-1:0] PLL_CFG_RST = 16'h0000;
   localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

   // ------------------------------------------------------------------
   // Nominal frequencies of the sources and limits of the PLL, in MHz
   // ------------------------------------------------------------------
   localparam real         RING_OSC_MHZ  = 20.0;
   localparam real         REF_OSC_MHZ   = 4.0;
   localparam real         EXT_MAX_MHZ   = 20.0;
   localparam real         PLL_IN_MIN    = 1.0;
   localparam real         PLL_IN_MAX    = 50.0;
   localparam real         PLL_OUT_MIN   = 62.5;
   localparam real         PLL_OUT_MAX   = 300.0;

endpackage : clk_ctrl_pkg

// ---- rtl/clk_switch.sv ----
`timescale 1ns/10ps
`default_nettype none

module clk_switch #(
   parameter int N = 3
) (
   // Clock and reset
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   // Source clocks, sampled levels, and selection
   input  wire logic [N-1:0]         clk_in,
   input  wire logic [$clog2(N)-1:0] sel,
   // Switched clock and status
   output logic                      clk_out,
   output logic [$clog2(N)-1:0]      active,
   output logic                      busy
);

   typedef enum logic [0:0] {RUN, WAIT_NEW} sw_state_e;

   sw_state_e               st_q;
   sw_state_e               st_d;
   logic [$clog2(N)-1:0]    cur_q;
   logic [$clog2(N)-1:0]    cur_d;
   logic                    en_q;
   logic                    en_d;
   logic                    out_q;
   wire logic               cur_lvl = clk_in[cur_q];

   // Break before make: the old source is cut only while it is low and the
   // new one is let through only once it is low, so no short pulse escapes.
   always_comb
   begin
      st_d  = st_q;
      cur_d = cur_q;
      en_d  = en_q;
      case (st_q)
         RUN:
         begin
            if (sel != cur_q && !cur_lvl)
            begin
               cur_d = sel;
               en_d  = 1'b0;
               st_d  = WAIT_NEW;
            end
         end
         WAIT_NEW:
         begin
            if (!cur_lvl)
            begin
               en_d = 1'b1;
               st_d = RUN;
            end
         end
         default:
         begin
            st_d = RUN;
            en_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_q  <= RUN;
         cur_q <= '0;
         en_q  <= 1'b1;
         out_q <= 1'b0;
      end
      else
      begin
         st_q  <= st_d;
         cur_q <= cur_d;
         en_q  <= en_d;
         out_q <= en_q & cur_lvl;
      end
   end

   assign clk_out = out_q;
   assign active  = cur_q;
   assign busy    = (st_q != RUN);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_switch_quiet: assert property ((st_q == WAIT_NEW) |=> !out_q)
      else $error("switched clock pulsed during source change");
   a_switch_follow: assert property ((st_q == RUN && $past(st_q) == RUN && $past(en_q) && $past(presetn))
                                     |-> out_q == $past(cur_lvl))
      else $error("switched clock does not follow its source");

endmodule : clk_switch

`default_nettype wire

// ---- rtl/clk_div_gate.sv ----
`timescale 1ns/10ps
`default_nettype none

module clk_div_gate
   import clk_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Input clock level, divide setting and gate
   input  wire logic             clk_in,
   input  wire logic [DIV_W-1:0] div,
   input  wire logic             run,
   // Divided and gated clock
   output logic                  clk_out
);

   logic             prev_q;
   logic [DIV_W-1:0] cnt_q;
   logic [DIV_W-1:0] cnt_d;
   logic             out_q;
   logic             out_d;
   wire logic        edge_seen = (clk_in != prev_q);
   wire logic        wrap      = (cnt_q == div);

   // The output toggles every div+1 input edges, which divides by div+1 with
   // an even duty cycle for odd ratios too. A closed gate lets the output
   // fall but never rise, so stopping leaves no runt pulse.
   // count and toggle
   always_comb
   begin
      cnt_d = cnt_q;
      out_d = out_q;
      if (!run && !out_q)
         cnt_d = DIV_BY_ONE;
      else if (edge_seen)
      begin
         if (wrap)
         begin
            cnt_d = DIV_BY_ONE;
            out_d = !out_q;
         end
         else
            cnt_d = cnt_q + 3'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prev_q <= 1'b0;
         cnt_q  <= DIV_BY_ONE;
         out_q  <= 1'b0;
      end
      else
      begin
         prev_q <= clk_in;
         cnt_q  <= cnt_d;
         out_q  <= out_d;
      end
   end

   assign clk_out = out_q;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_gate_hold: assert property ((!run && !out_q) |=> !out_q)
      else $error("gated clock rose while its gate was closed");
   a_div_edge: assert property ($changed(out_q) |-> $past(edge_seen) && $past(wrap))
      else $error("divided clock changed off its count");

endmodule : clk_div_gate

`default_nettype wire

// ---- bench/clk_src_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module clk_src_model #(
   parameter int RH = 3,
   parameter int FH = 12,
   parameter int EH = 4,
   parameter int PH = 2
) (
   // Clock
   input  wire logic pclk,
   // Controls from the clock controller
   input  wire logic ring_osc_enable,
   input  wire logic pll_enable,
   // Source clocks and PLL macro
   output logic      ring_osc_clock,
   output logic      reference_clock,
   output logic      external_input_clock,
   output logic      pll_output_clock,
   output logic      pll_lock
);
   int t = 0;
   int lk = 0;
   // sources stay in range.
   // The oscillators run through reset, as real ones do; a stopped one drives low.
   always_ff @(posedge pclk)
   begin
      t                    <= t + 1;
      ring_osc_clock       <= ring_osc_enable && (t % (2 * RH)) < RH;
      reference_clock      <= (t % (2 * FH)) < FH;
      external_input_clock <= (t % (2 * EH)) < EH;
      pll_output_clock     <= pll_enable && (t % (2 * PH)) < PH;
      lk                   <= pll_enable ? lk + 1 : 0;
      pll_lock             <= lk > 8;
   end
endmodule : clk_src_model

`default_nettype wire

// ---- bench/system_clock_tree_control_test.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; $display("BAD %0t mismatch", $time); end end

module system_clock_tree_control_test;
   import clk_ctrl_pkg::*;
   localparam int RH = 3, FH = 12, EH = 4, PH = 2;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, deep_sleep = 0, live = 0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, d, seed = 32'h0b28;
   logic pready, pslverr, ring_osc_clock, reference_clock, external_input_clock, pll_output_clock, pll_lock;
   logic pll_enable, pll_bypass, ring_osc_enable, free_running_clock, windowed_watchdog_clock;
   logic power_manager_logic_clock, system_clock, aux_clock, ahb_clock, periph_clock, ring_p, ref_p;
   logic [PLL_CFG_W-1:0] pll_config;
   logic [3:0] acc;
   int num_errors = 0, n_compared = 0;
   wire logic [4:0] dclk = {system_clock, free_running_clock, periph_clock, ahb_clock, aux_clock};
   always #5 pclk = ~pclk;
   clock_controller i_clock_controller(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .ring_osc_clock, .reference_clock, .external_input_clock, .pll_output_clock,
      .pll_lock, .pll_enable, .pll_bypass, .pll_config, .ring_osc_enable, .deep_sleep, .free_running_clock,
      .windowed_watchdog_clock, .power_manager_logic_clock, .system_clock, .aux_clock, .ahb_clock,
      .periph_clock);
   clk_src_model #(.RH(RH), .FH(FH), .EH(EH), .PH(PH)) i_clk_src_model(.pclk, .ring_osc_enable, .pll_enable,
      .ring_osc_clock, .reference_clock, .external_input_clock, .pll_output_clock, .pll_lock);
   always @(posedge pclk)
   begin
      ring_p <= ring_osc_clock;
      ref_p  <= reference_clock;
   end
   always @(negedge pclk)
      if (live)
      begin
         `CHK(windowed_watchdog_clock, ring_p)
         `CHK(power_manager_logic_clock, ref_p)
      end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic int half(input logic [1:0] s);
      return (s == SRC_REF) ? FH : (s == SRC_EXT) ? EH : RH;
   endfunction : half
   task automatic end_of_test;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test
   task automatic tmo;
      num_errors++;
      end_of_test;
   endtask : tmo
   // Waits for pready however long the slave takes, up to the bench limit.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int c;
      c = 0;
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
      @(posedge pclk);
      penable <= 1;
      do begin @(posedge pclk); c++; end while (pready !== 1'b1 && c < 20);
      if (c >= 20) tmo;
      rd = prdata; err = pslverr;
      psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask : apb
   task automatic settle;
      int c;
      c = 0;
      // A switch only shows busy once the old source is low, so give it time to start.
      repeat (30) @(posedge pclk);
      do begin apb(0, ADDR_STAT, 0); c++; end while (rd[9:8] !== 2'h0 && c < 40);
      if (c >= 40) tmo;
   endtask : settle
   task automatic wait_lvl(input int k, input logic v);
      int c;
      c = 0;
      do begin @(posedge pclk); c++; end while (dclk[k] !== v && c < 3000);
      if (c >= 3000) tmo;
   endtask : wait_lvl
   // The high phase after the next falling edge is measured, so a change of divider never shows a partial pulse.
   task automatic hi_len(input int k, input int n);
      int c;
      c = 0;
      wait_lvl(k, 1); wait_lvl(k, 0); wait_lvl(k, 1);
      while (dclk[k] === 1'b1 && c < 3000) begin @(posedge pclk); c++; end
      `CHK(c, n)
   endtask : hi_len
   task automatic quiet(input logic [3:0] want);
      repeat (40) @(posedge pclk);
      acc = 4'h0;
      repeat (120) begin @(posedge pclk); acc = acc | dclk[3:0]; end
      `CHK(acc, want)
   endtask : quiet
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1;
      repeat (4) @(posedge pclk);
      live <= 1;
      `CHK({ring_osc_enable, pll_enable}, 2'h2)
      for (int a = 0; a < 6; a++) begin apb(0, 12'(a * 4), 0); `CHK({err, rd}, {a == 5, ZERO_WORD}) end
      hi_len(0, RH);
      hi_len(2, RH);
      apb(1, ADDR_STAT, 32'hffff_ffff); `CHK(err, 1'b1)
      apb(1, ADDR_SRC, 32'h100); @(posedge pclk); `CHK(ring_osc_enable, 1'b0)
      for (int s = 3; s >= 0; s--) begin apb(1, ADDR_SRC, 32'(s)); settle; `CHK(rd[1:0], 2'(s % 3)) hi_len(3, half(2'(s % 3))); end
      apb(1, ADDR_SRC, 32'(SRC_EXT)); settle;
      for (int i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         d = (i == 0) ? 32'h777 : seed & 32'h777;
         apb(1, ADDR_DIV, d);
         hi_len(0, (d[2:0] + 1) * EH); hi_len(1, (d[6:4] + 1) * EH); hi_len(2, (d[6:4] + 1) * (d[10:8] + 1) * EH);
      end
      apb(1, ADDR_DIV, 0); deep_sleep <= 1; quiet(4'he);
      apb(1, ADDR_GATE, 1); quiet(4'h8);
      apb(1, ADDR_GATE, 2); quiet(4'ha);
      apb(1, ADDR_GATE, 0); deep_sleep <= 0; quiet(4'hf);
      // PLL fed from the reference oscillator only.
      apb(1, ADDR_SRC, 32'(SRC_REF)); settle;
      apb(1, ADDR_PLL, {8'h00, seed[15:0], 8'h01}); @(posedge pclk);
      `CHK({pll_enable, pll_bypass, pll_config}, {2'h2, seed[15:0]})
      for (int c = 0; c < 40 && rd[12] !== 1'b1; c++) apb(0, ADDR_STAT, 0);
      `CHK(rd[12], 1'b1)
      apb(1, ADDR_SRC, 32'h11); settle; `CHK(rd[4], 1'b1) hi_len(0, PH); hi_len(4, PH);
      apb(1, ADDR_PLL, {8'h00, seed[15:0], 8'h03}); settle; hi_len(0, FH);
      `CHK(pll_config, seed[15:0])
      end_of_test;
   end
endmodule : system_clock_tree_control_test

`default_nettype wire
